// ===== core/pedc_top.sv
// PHY energy-detect control register bank with APB slave and interrupt.
// Assumes raw line pins are asynchronous; transmit_request is on clock.
//
// What this block does
// (R1) Enable lets PHY power follow energy status
// (R2) Low threshold bit selects the sensitive detector
// (R3) Force bit reports link up at 100 Mbps
// (R4) Software sets force bit only when testing
// (R5) Status reads one if energy within window
// (R6) Software writes zero to reserved bit positions
// (R7) Reset clears writable bits, status reads one
// (R8) Software reinitialises after external supply removal
// (R9) Unlinked power-down holds transmit requests off
// (R10) No link pulses while powered down
// (R11) Writes change only writable control bits
`timescale 1ns/1ns
module pedc_top
    import pedc_pkg::*;
#(
    parameter int ED_WINDOW_CYC = ED_WINDOW_CYCLES
) (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              energy_normal_raw,
    input  wire logic              energy_low_raw,
    input  wire logic              partner_link_raw,
    input  wire logic              speed_100_raw,
    input  wire logic              transmit_request,
    output logic                   irq,
    output logic                   phy_power_up,
    output logic                   link_pulse_en,
    output logic                   link_up,
    output logic                   tx_permit
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    pedc_energy_if eif ();

    logic [PIN_N-1:0]  pin_raw;
    logic [PIN_N-1:0]  meta_reg;
    logic [PIN_N-1:0]  sync_reg;
    logic [CTRL_W-1:0] ctrl_reg,   ctrl_next;
    logic [EVT_N-1:0]  stat_reg,   stat_next;
    logic [EVT_N-1:0]  mask_reg,   mask_next;
    logic [EVT_N-1:0]  evt;
    logic              ed_status_reg, ed_status_next;
    pedc_pwr_e         pwr_reg,    pwr_next;
    logic              link_reg,   link_next;
    logic              txp_reg,    txp_next;
    logic              pulse_reg,  pulse_next;
    logic              pwrup_reg,  pwrup_next;
    logic              irq_reg,    irq_next;
    logic [DATA_W-1:0] prdata_reg, prdata_next;
    logic              pready_reg, pready_next;
    logic              perr_reg,   perr_next;
    logic              access;
    logic              done_wr;
    logic              tx_hold;
    pedc_dec_e         wr_sel;

    // Decode shared by the write path and the read path
    function automatic pedc_dec_e decode(input logic [ADDR_W-1:0] a);
        case (a)
            OFF_CTRL:     decode = PEDC_DEC_CTRL;
            OFF_IRQ_STAT: decode = PEDC_DEC_STAT;
            OFF_IRQ_MASK: decode = PEDC_DEC_MASK;
            OFF_STATE:    decode = PEDC_DEC_STATE;
            default:      decode = PEDC_DEC_NONE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    assign pin_raw = {speed_100_raw, partner_link_raw,
                      energy_low_raw, energy_normal_raw};

    // Two stages; only the second stage is read by logic
    generate
        for (genvar i = 0; i < PIN_N; i++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!rst_b) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= pin_raw[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Energy window
    // ----------------------------------------------------------------
    // The low threshold detector fires on weaker signals than normal
    assign eif.energy_hit = ctrl_reg[BIT_LOW_THRESH] ?        // R2
                            sync_reg[PIN_E_LOW] : sync_reg[PIN_E_NORMAL];

    pedc_energy_timer #(
        .WINDOW_CYC (ED_WINDOW_CYC)
    ) u_timer (
        .clock (clock),
        .rst_b (rst_b),
        .eif   (eif)
    );

    // ----------------------------------------------------------------
    // PHY power, link and transmit gating
    // ----------------------------------------------------------------
    assign tx_hold = ctrl_reg[BIT_ED_ENABLE] && !link_reg;

    always_comb begin
        ed_status_next = eif.window_active;                       // R5
        pwr_next       = pwr_reg;
        case (pwr_reg)
            PEDC_PWR_ON: begin
                if (ctrl_reg[BIT_ED_ENABLE] && !ed_status_reg) begin
                    pwr_next = PEDC_PWR_DOWN;                     // R1
                end
            end
            PEDC_PWR_DOWN: begin
                if (!ctrl_reg[BIT_ED_ENABLE] || ed_status_reg) begin
                    pwr_next = PEDC_PWR_ON;                       // R1
                end
            end
            default: pwr_next = PEDC_PWR_ON;
        endcase
        pwrup_next = (pwr_next == PEDC_PWR_ON);
        // Only listens while down, so pulses follow the power state
        pulse_next = pwrup_next;                                  // R10
        // Forced link is a test aid and ignores the partner at 100 Mbps
        link_next  = (ctrl_reg[BIT_FORCE_LINK] && sync_reg[PIN_SPEED100])
                     || (pwrup_next && sync_reg[PIN_PARTNER]);    // R3
        // With energy detect enabled, a request stays with its owner until the link is up
        txp_next   = transmit_request && !tx_hold;                // R9
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ed_status_reg <= 1'b1;                                // R7
            pwr_reg       <= PEDC_PWR_ON;
            pwrup_reg     <= 1'b1;
            pulse_reg     <= 1'b1;
            link_reg      <= 1'b0;
            txp_reg       <= 1'b0;
        end else begin
            ed_status_reg <= ed_status_next;
            pwr_reg       <= pwr_next;
            pwrup_reg     <= pwrup_next;
            pulse_reg     <= pulse_next;
            link_reg      <= link_next;
            txp_reg       <= txp_next;
        end
    end

    // ----------------------------------------------------------------
    // APB slave and registers
    // ----------------------------------------------------------------
    // One wait state gives a registered prdata without a read mux path
    assign access  = psel && penable;
    assign done_wr = access && pready_reg && pwrite;
    assign wr_sel  = decode(paddr);

    assign evt[EVT_ENERGY_ON]  = ed_status_next && !ed_status_reg;
    assign evt[EVT_ENERGY_OFF] = !ed_status_next && ed_status_reg;
    assign evt[EVT_LINK_CHG]   = link_next != link_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        if (done_wr && wr_sel == PEDC_DEC_CTRL) begin
            ctrl_next = pwdata[CTRL_W-1:0] & CTRL_WMASK;          // R11
        end
        if (done_wr && wr_sel == PEDC_DEC_MASK) begin
            mask_next = pwdata[EVT_N-1:0];
        end
        // A new event beats a same-cycle write-one clear
        for (int i = 0; i < EVT_N; i++) begin
            stat_next[i] = evt[i] || (stat_reg[i] && !(done_wr
                           && wr_sel == PEDC_DEC_STAT && pwdata[i]));
        end
        irq_next    = |(stat_next & mask_next);
        pready_next = access && !pready_reg;
        perr_next   = pready_next && (decode(paddr) == PEDC_DEC_NONE);
        prdata_next = '0;
        if (pready_next && !pwrite) begin
            case (decode(paddr))
                PEDC_DEC_CTRL: prdata_next[CTRL_W-1:0] =
                    ctrl_reg | (CTRL_W'(ed_status_reg) << BIT_ED_STATUS);
                PEDC_DEC_STAT: prdata_next[EVT_N-1:0] = stat_reg;
                PEDC_DEC_MASK: prdata_next[EVT_N-1:0] = mask_reg;
                PEDC_DEC_STATE: begin
                    prdata_next[ST_PHY_ON]  = pwrup_reg;
                    prdata_next[ST_LINK_UP] = link_reg;
                    prdata_next[ST_TX_HOLD] = tx_hold;
                end
                default: prdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_reg   <= CTRL_RESET;                             // R7
            stat_reg   <= '0;
            mask_reg   <= '0;
            irq_reg    <= 1'b0;
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            perr_reg   <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            stat_reg   <= stat_next;
            mask_reg   <= mask_next;
            irq_reg    <= irq_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            perr_reg   <= perr_next;
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = perr_reg;
    assign irq           = irq_reg;
    assign phy_power_up  = pwrup_reg;
    assign link_pulse_en = pulse_reg;
    assign link_up       = link_reg;
    assign tx_permit     = txp_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_ctrl_setup;
        access && !pready_reg && pwrite && paddr == OFF_CTRL;
    endsequence
    sequence s_ctrl_write;
        s_ctrl_setup ##1 (access && pready_reg);
    endsequence

    a_pwr_goes_down: assert property (pwr_reg == PEDC_PWR_ON &&       // R1
        ctrl_reg[BIT_ED_ENABLE] && !ed_status_reg
        |=> pwr_reg == PEDC_PWR_DOWN && !phy_power_up)
        else $error("PHY not powered down without energy");
    a_pwr_stays_up: assert property (!ctrl_reg[BIT_ED_ENABLE]         // R1
        |=> phy_power_up)
        else $error("PHY powered down while feature disabled");
    a_low_thresh_wake: assert property (ctrl_reg[BIT_LOW_THRESH] &&   // R2
        sync_reg[PIN_E_LOW] |-> ##2 ed_status_reg)
        else $error("Low threshold energy did not set status");
    a_force_link_up: assert property (ctrl_reg[BIT_FORCE_LINK] &&     // R3
        sync_reg[PIN_SPEED100] |=> link_up)
        else $error("Forced link did not report up");
    a_status_cause: assert property ($rose(ed_status_reg)            // R5
        |-> $past(eif.energy_hit, 2))
        else $error("Status rose without energy");
    a_reset_values: assert property ($rose(rst_b)                    // R7
        |-> ed_status_reg && ctrl_reg == CTRL_RESET)
        else $error("Wrong register values after reset");
    a_tx_held_off: assert property (tx_hold |=> !tx_permit)          // R9
        else $error("Transmit permitted while unlinked in power-down");
    a_no_link_pulses: assert property (!phy_power_up                  // R10
        |-> !link_pulse_en)
        else $error("Link pulses while powered down");
    a_ctrl_wr_mask: assert property (s_ctrl_write |=>                 // R11
        ctrl_reg == ($past(pwdata[CTRL_W-1:0]) & CTRL_WMASK))
        else $error("Control write touched a non-writable bit");

endmodule

// ===== core/pedc_pkg.sv
// Package for the PHY energy-detect control block.
// Assumes a 50 MHz system clock and a 32-bit APB register bus.
package pedc_pkg;

    // ----------------------------------------------------------------
    // Bus and register map
    // ----------------------------------------------------------------
    localparam int         DATA_W       = 32;
    localparam int         ADDR_W       = 8;
    localparam int         CTRL_W       = 16;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFF_STATE    = 8'h0c;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int          BIT_ED_ENABLE  = 13;
    localparam int          BIT_LOW_THRESH = 11;
    localparam int          BIT_FORCE_LINK = 2;
    localparam int          BIT_ED_STATUS  = 1;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] CTRL_WMASK     = 16'h2804;

    // ----------------------------------------------------------------
    // Interrupt events and state word bits
    // ----------------------------------------------------------------
    localparam int EVT_N          = 3;
    localparam int EVT_ENERGY_ON  = 0;
    localparam int EVT_ENERGY_OFF = 1;
    localparam int EVT_LINK_CHG   = 2;
    localparam int ST_PHY_ON      = 0;
    localparam int ST_LINK_UP     = 1;
    localparam int ST_TX_HOLD     = 2;

    // ----------------------------------------------------------------
    // Synchronised pin inputs
    // ----------------------------------------------------------------
    localparam int PIN_N        = 4;
    localparam int PIN_E_NORMAL = 0;
    localparam int PIN_E_LOW    = 1;
    localparam int PIN_PARTNER  = 2;
    localparam int PIN_SPEED100 = 3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ           = 50_000_000;
    localparam int ED_WINDOW_MS     = 256;
    localparam int ED_WINDOW_CYCLES = (CLK_HZ / 1000) * ED_WINDOW_MS;

    typedef enum logic [1:0] {
        PEDC_PWR_ON   = 2'b00,
        PEDC_PWR_DOWN = 2'b01
    } pedc_pwr_e;

    typedef enum logic [2:0] {
        PEDC_DEC_CTRL  = 3'h0,
        PEDC_DEC_STAT  = 3'h1,
        PEDC_DEC_MASK  = 3'h2,
        PEDC_DEC_STATE = 3'h3,
        PEDC_DEC_NONE  = 3'h4
    } pedc_dec_e;

endpackage

// ===== core/pedc_energy_if.sv
// Link between the register core and the energy window timer.
// Both ends run on the same clock.
`timescale 1ns/1ns
interface pedc_energy_if;
    logic energy_hit;
    logic window_active;

    modport core  (output energy_hit, input  window_active);
    modport timer (input  energy_hit, output window_active);
endinterface

// ===== core/pedc_energy_timer.sv
// Retriggerable energy window: active while energy was seen recently.
// Assumes energy_hit is already synchronous to clock.
`timescale 1ns/1ns
module pedc_energy_timer
    import pedc_pkg::*;
#(
    parameter int WINDOW_CYC = ED_WINDOW_CYCLES
) (
    input  wire logic     clock,
    input  wire logic     rst_b,
    pedc_energy_if.timer  eif
);
    localparam int             CW   = $clog2(WINDOW_CYC + 1);
    localparam logic [CW-1:0]  LOAD = CW'(WINDOW_CYC);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;

    // Reload on every hit, otherwise run down to zero and stop
    always_comb begin
        count_next = count_reg;
        if (eif.energy_hit) begin
            count_next = LOAD;
        end else if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Starts full so the window reads active out of reset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            count_reg <= LOAD;
        end else begin
            count_reg <= count_next;
        end
    end

    assign eif.window_active = (count_reg != '0);

endmodule

// ===== sim/pedc_top_tb.sv
// Self-checking bench for the energy-detect control register bank.
// Assumes pedc_pkg and the core files are compiled first.
`timescale 1ns/1ns
module pedc_top_tb
    import pedc_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and design instance
    // ----------------------------------------------------------------
    localparam int WIN = 20;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic        err;
    } pedc_row_s;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, irq, tx_permit;
    logic energy_normal_raw = 1'b1, energy_low_raw = 1'b1;
    logic partner_link_raw = 1'b0, speed_100_raw = 1'b0;
    logic transmit_request = 1'b0, phy_power_up, link_pulse_en, link_up;
    logic [31:0] rd;
    logic        er;
    int          fail_count = 0;
    int          checks = 0;
    int          cnt;
    pedc_row_s   rows [9];

    pedc_top #(.ED_WINDOW_CYC(WIN)) DUT (
        .clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .energy_normal_raw(energy_normal_raw),
        .energy_low_raw(energy_low_raw),
        .partner_link_raw(partner_link_raw),
        .speed_100_raw(speed_100_raw),
        .transmit_request(transmit_request), .irq(irq),
        .phy_power_up(phy_power_up), .link_pulse_en(link_pulse_en),
        .link_up(link_up), .tx_permit(tx_permit));

    // Clock, 20 ns period
    initial begin
        forever #10 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // Compare, bus and closing tasks
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, pready, 1'b1);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait on the power output; the limit leaves slack for syncs
    task automatic wait_pwr(input logic v);
        cnt = 0;
        while (phy_power_up !== v && cnt < 100) begin
            @(posedge clock);
            cnt++;
        end
    endtask

    task automatic summarize;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        // Energy pins held high so the status bit stays set in the table
        // Control writes keep reserved positions at zero
        rows[0] = '{OFF_CTRL, 32'h00002806, 32'h00002806, 1'b0};
        rows[1] = '{OFF_CTRL, 32'h00000000, 32'h00000002, 1'b0};
        rows[2] = '{OFF_CTRL, 32'h00002000, 32'h00002002, 1'b0};
        rows[3] = '{OFF_CTRL, 32'h00000800, 32'h00000802, 1'b0};
        rows[4] = '{OFF_CTRL, 32'h00000004, 32'h00000006, 1'b0};
        rows[5] = '{OFF_CTRL, 32'h00000002, 32'h00000002, 1'b0};
        rows[6] = '{OFF_STATE, 32'hffffffff, 32'h00000001, 1'b0};
        rows[7] = '{8'h10, 32'hffffffff, 32'h00000000, 1'b1};
        rows[8] = '{OFF_IRQ_MASK, 32'hffffffff, 32'h00000007, 1'b0};
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        chk_bit(phy_power_up, 1'b1);
        chk_bit(link_up, 1'b0);
        apb(OFF_CTRL, 1'b0, 32'h0);
        chk_word(rd, 32'h00000002);
        $display("test reset values done");

        foreach (rows[i]) begin
            apb(rows[i].addr, 1'b1, rows[i].wdata);
            chk_bit(er, rows[i].err);
            apb(rows[i].addr, 1'b0, 32'h0);
            chk_word(rd, rows[i].exp);
            chk_bit(er, rows[i].err);
        end
        $display("test register table done");

        // Window expiry powers the PHY down; the low pin alone cannot wake
        apb(OFF_CTRL, 1'b1, 32'h00002000);
        apb(OFF_IRQ_STAT, 1'b1, 32'h7);
        energy_normal_raw <= 1'b0;
        energy_low_raw    <= 1'b0;
        wait_pwr(1'b0);
        chk_bit(cnt >= WIN && cnt <= WIN + 8, 1'b1);
        chk_bit(link_pulse_en, 1'b0);
        chk_bit(irq, 1'b1);
        apb(OFF_CTRL, 1'b0, 32'h0);
        chk_word(rd, 32'h00002000);
        apb(OFF_IRQ_STAT, 1'b0, 32'h0);
        chk_word(rd, 32'h00000002);
        apb(OFF_IRQ_STAT, 1'b1, 32'h2);
        // The clear lands on the accepting edge; look one edge later
        @(posedge clock);
        chk_bit(irq, 1'b0);
        energy_low_raw <= 1'b1;
        repeat (10) @(posedge clock);
        chk_bit(phy_power_up, 1'b0);
        apb(OFF_CTRL, 1'b1, 32'h00002800);
        wait_pwr(1'b1);
        chk_bit(phy_power_up, 1'b1);
        chk_bit(link_pulse_en, 1'b1);
        $display("test energy window done");

        // Transmit held off while enabled and unlinked
        transmit_request <= 1'b1;
        repeat (5) @(posedge clock);
        chk_bit(tx_permit, 1'b0);
        partner_link_raw <= 1'b1;
        repeat (6) @(posedge clock);
        chk_bit(link_up, 1'b1);
        chk_bit(tx_permit, 1'b1);
        partner_link_raw <= 1'b0;
        repeat (6) @(posedge clock);
        chk_bit(tx_permit, 1'b0);
        // Energy came back once, link changed twice: bits 0 and 2
        apb(OFF_IRQ_STAT, 1'b0, 32'h0);
        chk_word(rd, 32'h00000005);
        chk_bit(irq, 1'b1);
        $display("test transmit hold done");

        // Forced link at 100 Mbps; cleared before any speed change
        speed_100_raw <= 1'b1;
        apb(OFF_CTRL, 1'b1, 32'h00002804);
        repeat (6) @(posedge clock);
        chk_bit(link_up, 1'b1);
        apb(OFF_CTRL, 1'b1, 32'h00002800);
        repeat (6) @(posedge clock);
        chk_bit(link_up, 1'b0);
        apb(OFF_CTRL, 1'b1, 32'h0);
        repeat (4) @(posedge clock);
        chk_bit(tx_permit, 1'b1);
        $display("test force link done");

        // Reset in mid-run, then read back the control and mask reset values
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        chk_bit(irq, 1'b0);
        chk_bit(phy_power_up, 1'b1);
        apb(OFF_CTRL, 1'b0, 32'h0);
        chk_word(rd, 32'h00000002);
        apb(OFF_IRQ_MASK, 1'b0, 32'h0);
        chk_word(rd, 32'h00000000);
        $display("test second reset done");
        summarize();
    end
endmodule
